// file: bench/oag_dec_model.sv
// Decoder-side model: drives address requests and prefetches.
// Assumes the bench calls its task from one process at a time.
`timescale 1ns/1ps

module oag_dec_model (
  // Clock
  input wire logic mclk,
  // Requests toward the generator
  output oag_pkg::oag_req_t req_o,
  output oag_pkg::oag_mac_t mac_o
);
  // ------------------------------------------------------------
  // Idle at time zero
  // ------------------------------------------------------------
  initial
  begin
    req_o = '0;
    mac_o = '0;
  end

  // One cycle of request; idle payload is scrambled, valid low
  task automatic issue(input oag_pkg::oag_req_t r,
    input oag_pkg::oag_mac_t m);
    @(posedge mclk);
    req_o <= r;
    mac_o <= m;
    @(posedge mclk);
    req_o <= {1'b0, ~r[$bits(r)-2:0]};
    mac_o <= {1'b0, ~m[$bits(m)-2:0]};
    #1;
  endtask
endmodule

// file: bench/tb_top.sv
// Self-checking bench of the operand address generator.
// Assumes results one clock after a request, ack one after a bus cycle.
`timescale 1ns/1ps

module tb_top;
  // Clock, reset and bus
  logic mclk, rst_b, cyc, stb, we, ack, bad;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  // Datapath
  logic [15:0] op1;
  oag_pkg::oag_req_t req;
  oag_pkg::oag_mac_t mac;
  oag_pkg::oag_res_t [3:0] res;
  // Bookkeeping
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;

  // ------------------------------------------------------------
  // Design and decoder model
  // ------------------------------------------------------------
  oag_addr_gen dut (.mclk(mclk), .rst_b(rst_b), .req_i(req),
    .mac_i(mac), .res_o(res), .op1_o(op1), .mac_bad_o(bad),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));
  oag_dec_model dm (.mclk(mclk), .req_o(req), .mac_o(mac));

  // Clock at 40 MHz
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // Hang guard
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      n_errors++;
      test_done;
    end
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  // Counts and prints verdict
  task automatic test_done;
    $display("Checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Compare one value
  task automatic chk(input string n, input logic [31:0] got, exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", n, exp, got);
    end
  endtask

  // Classic single bus cycle; waits for ack
  task automatic wb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h3;
    wdat <= d;
    do @(posedge mclk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge mclk);
  endtask

  // Builds one slot
  function automatic oag_pkg::oag_slot_t sl(oag_pkg::oag_mode_t md,
    logic y, logic [3:0] i, logic [15:0] v, logic [15:0] s);
    return '{md, y, i, v, s};
  endfunction

  // One move-type request
  task automatic go(input oag_pkg::oag_slot_t s, d,
    input logic [15:0] o, l);
    dm.issue('{1'b1, s, d, o, l}, '0);
  endtask

  // Result of one slot
  task automatic cr(input int k, input logic [15:0] ea,
    input logic wen, input logic [15:0] wv);
    chk("valid", res[k].valid, 1'b1);
    chk("ea", res[k].ea, ea);
    chk("wr_en", res[k].wr_en, wen);
    if (wen)
      chk("wr_val", res[k].wr_val, wv);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  // Reset values, read-write, unmapped place
  task automatic t_regs;
    logic [31:0] q;
    wb(1'b0, 8'h00, 32'h0, q);
    chk("ctrl reset", q, 32'h0000_00FF);
    for (int i = 1; i < 5; i++)
    begin
      wb(1'b0, 8'(i * 4), 32'h0, q);
      chk("bound reset", q, 32'h0);
    end
    wb(1'b1, 8'h04, 32'hFFFF_1234, q);
    wb(1'b0, 8'h04, 32'h0, q);
    chk("start rw", q, 32'h0000_1234);
    wb(1'b1, 8'h18, 32'h0000_5555, q);
    wb(1'b0, 8'h18, 32'h0, q);
    chk("unmapped", q, 32'h0);
    $display("t_regs done");
  endtask

  // Plain addressing forms, circular off
  task automatic t_modes;
    go(sl(oag_pkg::M_POST, 0, 1, 16'h1000, 16'h0002),
      sl(oag_pkg::M_PRE, 0, 2, 16'h2000, 16'hFFFE), 16'h0030, 0);
    cr(0, 16'h1000, 1, 16'h1002);
    cr(1, 16'h1FFE, 1, 16'h1FFE);
    chk("op1", op1, 16'h0030);
    go(sl(oag_pkg::M_IDX, 0, 3, 16'h0100, 0),
      sl(oag_pkg::M_IDX, 0, 4, 16'h0400, 0), 16'h0022, 16'h0010);
    cr(0, 16'h0122, 0, 0);
    cr(1, 16'h0422, 0, 0);
    go(sl(oag_pkg::M_LITOFF, 0, 5, 16'h0500, 0),
      sl(oag_pkg::M_IND, 0, 6, 16'h0600, 0), 16'h0001, 16'h0040);
    cr(0, 16'h0540, 0, 0);
    cr(1, 16'h0600, 0, 0);
    go(sl(oag_pkg::M_FILE, 0, 0, 16'h7777, 0),
      sl(oag_pkg::M_INTERRUPT_DISABLE_INSTR, 0, 0, 0, 0), 0, 16'hFFFF);
    chk("file ea", res[0].ea, 16'h1FFF);
    chk("interrupt_disable_instr lit", res[1].opnd, 16'h3FFF);
    go(sl(oag_pkg::M_BRA, 0, 0, 0, 0),
      sl(oag_pkg::M_LIT5, 0, 0, 0, 0), 0, 16'h80FF);
    chk("bra lit", res[0].opnd, 16'h80FF);
    chk("lit5", res[1].opnd, 16'h001F);
    $display("t_modes done");
  endtask

  // Circular correction in X and Y
  task automatic t_circ;
    logic [31:0] q;
    wb(1'b1, 8'h04, 32'h1000, q);
    wb(1'b1, 8'h08, 32'h101F, q);
    wb(1'b1, 8'h0C, 32'h2000, q);
    wb(1'b1, 8'h10, 32'h203F, q);
    wb(1'b1, 8'h00, 32'h0000_C025, q);
    go(sl(oag_pkg::M_POST, 0, 5, 16'h101E, 16'h0004),
      sl(oag_pkg::M_PRE, 0, 5, 16'h1000, 16'hFFFE), 0, 0);
    cr(0, 16'h101E, 1, 16'h1002);
    cr(1, 16'h101E, 1, 16'h101E);
    chk("circ", res[0].circ, 1'b1);
    go(sl(oag_pkg::M_IDX, 0, 5, 16'h101C, 0),
      sl(oag_pkg::M_POST, 1, 2, 16'h2001, 16'h0002), 16'h0008, 0);
    cr(0, 16'h1004, 0, 0);
    cr(1, 16'h2000, 1, 16'h2002);
    go(sl(oag_pkg::M_POST, 0, 6, 16'h101E, 16'h0004),
      sl(oag_pkg::M_POST, 1, 2, 16'h203E, 16'h0004), 0, 0);
    cr(0, 16'h101E, 1, 16'h1022);
    cr(1, 16'h203E, 1, 16'h2002);
    wb(1'b1, 8'h00, 32'h0000_802F, q);
    go(sl(oag_pkg::M_POST, 0, 15, 16'h101E, 16'h0004),
      sl(oag_pkg::M_POST, 1, 2, 16'h203E, 16'h0004), 0, 0);
    cr(0, 16'h101E, 1, 16'h1022);
    cr(1, 16'h203E, 1, 16'h2042);
    wb(1'b0, 8'h14, 32'h0, q);
    chk("last ea", q, 32'h0000_101E);
    $display("t_circ done");
  endtask

  // Dual prefetch routing and forms
  task automatic t_mac;
    oag_pkg::oag_mac_t m;
    oag_pkg::oag_mac_mode_t md[3];
    md = '{oag_pkg::MAC_POST2, oag_pkg::MAC_POST4, oag_pkg::MAC_POST6};
    m = '{1'b1, 1'b1, oag_pkg::MAC_IDX, 1'b1, oag_pkg::MAC_POST4,
      16'h0800, 16'h0900, 16'h1800, 16'h1900, 16'h0006};
    dm.issue('0, m);
    cr(2, 16'h0906, 0, 0);
    cr(3, 16'h1900, 1, 16'h1904);
    chk("y idx", res[3].wr_idx, 4'hB);
    chk("bad", bad, 1'b0);
    m.x_sel = 1'b0;
    dm.issue('0, m);
    cr(2, 16'h0800, 0, 0);
    chk("bad", bad, 1'b1);
    for (int i = 0; i < 3; i++)
    begin
      m.x_mode = md[i];
      dm.issue('0, m);
      cr(2, 16'h0800, 1, 16'h0800 + 16'(2 * i + 2));
      chk("x idx", res[2].wr_idx, 4'h8);
    end
    m.x_mode = oag_pkg::MAC_IND;
    dm.issue('0, m);
    cr(2, 16'h0800, 0, 0);
    $display("t_mac done");
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    rst_b = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0;
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    t_regs;
    t_modes;
    t_circ;
    t_mac;
    test_done;
  end
endmodule

// file: design/oag_addr_gen.sv
// Operand address generator with circular-buffer correction and
// a classic Wishbone register slave.
// Assumes the decoder supplies pointer values; results follow one
// clock later, and write-backs go to the register file outside.
//
// Added by the designer: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`include "oag_defines.svh"

// Summary of operation
// - File address is 13-bit direct, low 8192
// - Operand one always a direct working register
// - Post-modify: old pointer is address, then step
// - Pre-modify: step pointer first, use result
// - Indexed: pointer plus offset register
// - Literal offset: pointer plus instruction literal
// - Move slots share one offset register field
// - Prefetch: 8/9 to X, 10/11 to Y
// - Prefetch indexing only on registers 9, 11
// - Prefetch: indirect, post 2/4/6, indexed only
// - Branch 16-bit signed, disable 14-bit unsigned
// - One X buffer, one Y buffer, any pointer but 15
// - Check upper bound rising, lower falling
// - Power-of-two buffers check both bounds
// - Length from 16-bit start/end, 32K words
// - Y circular addresses keep bit 0 clear
// - X select bits 3:0, enable bit 15
// - Y select bits 7:4, enable bit 14
// - Bound compare beyond, not only equal
// - Write back wrapped pointer only when modified
module oag_addr_gen (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Decoder requests
  input wire oag_pkg::oag_req_t req_i,
  input wire oag_pkg::oag_mac_t mac_i,
  // Results: slot 0 source, 1 destination, 2 prefetch X, 3 Y
  output oag_pkg::oag_res_t [3:0] res_o,
  output logic [15:0] op1_o,
  output logic mac_bad_o,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------

  // Map bus address to register index, 7 when unmapped
  function automatic logic [2:0] reg_idx(input logic [7:0] adr);
    logic [2:0] i;
    i = 3'h7;
    if (adr[7:5] == 3'h0 && adr[4:2] <= 3'h5)
      i = adr[4:2];
    return i;
  endfunction

  // Wrap an address back into the buffer
  function automatic logic [15:0] wrap(input logic [15:0] a,
    input logic dn, input logic [15:0] s, input logic [15:0] e);
    logic [16:0] len;
    logic p2;
    logic [15:0] r;
    len = {1'b0, e} - {1'b0, s} + 17'h0_0001;
    p2 = (len & (len - 17'h0_0001)) == 17'h0_0000;
    r = a;
    if ((!dn || p2) && a > e)
      r = a - len[15:0];
    else if ((dn || p2) && a < s)
      r = a + len[15:0];
    return r;
  endfunction

  // Turn a prefetch request into a slot
  function automatic oag_pkg::oag_slot_t mac_slot(
    input oag_pkg::oag_mac_mode_t m, input logic y, input logic sel,
    input logic [15:0] va, input logic [15:0] vb);
    oag_pkg::oag_slot_t s;
    s.space_y = y;
    s.wn_idx = {1'b1, 1'b0, y, sel};
    s.wn_val = sel ? vb : va;
    s.step = 16'h0000;
    s.mode = oag_pkg::M_IND;
    case (m)
      oag_pkg::MAC_POST2:
      begin
        s.mode = oag_pkg::M_POST;
        s.step = 16'h0002;
      end
      oag_pkg::MAC_POST4:
      begin
        s.mode = oag_pkg::M_POST;
        s.step = 16'h0004;
      end
      oag_pkg::MAC_POST6:
      begin
        s.mode = oag_pkg::M_POST;
        s.step = 16'h0006;
      end
      // Indexing only on the odd pointer
      oag_pkg::MAC_IDX:
        s.mode = sel ? oag_pkg::M_IDX : oag_pkg::M_IND;
      default:
        s.mode = oag_pkg::M_IND;
    endcase
    return s;
  endfunction

  // Effective address of one slot
  function automatic oag_pkg::oag_res_t calc(
    input oag_pkg::oag_slot_t s, input logic v,
    input logic [15:0] ofs, input logic [15:0] lit,
    input logic [15:0] ctl, input logic [15:0] xs,
    input logic [15:0] xe, input logic [15:0] ys,
    input logic [15:0] ye);
    oag_pkg::oag_res_t r;
    logic act;
    logic modif;
    logic [15:0] delta;
    logic [15:0] sum;
    r = '0;
    r.valid = v;
    r.wr_idx = s.wn_idx;
    // Circular selection per space
    if (s.space_y)
      act = ctl[`OAG_Y_EN_BIT] &&
        ctl[`OAG_YSEL_MSB:`OAG_YSEL_LSB] != `OAG_SEL_OFF &&
        ctl[`OAG_YSEL_MSB:`OAG_YSEL_LSB] == s.wn_idx;
    else
      act = ctl[`OAG_X_EN_BIT] &&
        ctl[`OAG_XSEL_MSB:`OAG_XSEL_LSB] != `OAG_SEL_OFF &&
        ctl[`OAG_XSEL_MSB:`OAG_XSEL_LSB] == s.wn_idx;
    // Pointer adjustment for each mode
    case (s.mode)
      oag_pkg::M_POST, oag_pkg::M_PRE: delta = s.step;
      oag_pkg::M_IDX: delta = ofs;
      oag_pkg::M_LITOFF: delta = lit;
      default: delta = 16'h0000;
    endcase
    modif = s.mode inside {oag_pkg::M_POST, oag_pkg::M_PRE,
      oag_pkg::M_IDX, oag_pkg::M_LITOFF};
    sum = s.wn_val + delta;
    // Circular correction, direction from sign of adjustment
    if (act && modif)
      sum = s.space_y ? wrap(sum, delta[15], ys, ye) :
        wrap(sum, delta[15], xs, xe);
    r.circ = act;
    case (s.mode)
      oag_pkg::M_FILE:
        r.ea = {3'b000, lit[`OAG_FILE_BITS-1:0]};
      oag_pkg::M_DIRECT:
        r.opnd = s.wn_val;
      oag_pkg::M_IND:
        r.ea = s.wn_val;
      // Old pointer addresses, stepped value written back
      oag_pkg::M_POST:
      begin
        r.ea = s.wn_val;
        r.wr_en = 1'b1;
        r.wr_val = sum;
      end
      // Stepped value both addresses and is written back
      oag_pkg::M_PRE:
      begin
        r.ea = sum;
        r.wr_en = 1'b1;
        r.wr_val = sum;
      end
      // Offset forms leave the pointer untouched
      oag_pkg::M_IDX, oag_pkg::M_LITOFF:
        r.ea = sum;
      oag_pkg::M_LIT5:
        r.opnd = {11'h000, lit[4:0]};
      oag_pkg::M_BRA:
        r.opnd = lit;
      oag_pkg::M_INTERRUPT_DISABLE_INSTR:
        r.opnd = {2'b00, lit[13:0]};
      default:
        r.ea = 16'h0000;
    endcase
    // Y buffer holds words only
    if (act && s.space_y)
    begin
      r.ea[0] = 1'b0;
      r.wr_val[0] = 1'b0;
    end
    if (!v)
      r.wr_en = 1'b0;
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Configuration and bus state
  // ----------------------------------------------------------------
  oag_pkg::oag_bus_state_t bus_reg, bus_next; // Slave state
  logic [15:0] cfg_reg [0:`OAG_NUM_CFG-1]; // Control and bounds
  logic [15:0] cfg_next [0:`OAG_NUM_CFG-1];
  logic [31:0] dat_reg, dat_next; // Read data
  logic [15:0] last_ea_reg, last_ea_next; // Last source address
  logic [2:0] rd_idx; // Decoded bus index

  // ----------------------------------------------------------------
  // Address datapath
  // ----------------------------------------------------------------
  oag_pkg::oag_slot_t [3:0] slot; // Assembled slots
  logic [3:0] slot_v; // Slot valid
  oag_pkg::oag_res_t [3:0] res_reg, res_next; // Slot results
  logic [15:0] op1_reg, op1_next; // Register-direct operand
  logic mac_bad_reg, mac_bad_next; // Illegal prefetch form

  // Slot assembly from both request ports
  always_comb
  begin
    slot[0] = req_i.src;
    slot[1] = req_i.dst;
    slot[2] = mac_slot(mac_i.x_mode, 1'b0, mac_i.x_sel, mac_i.w8,
      mac_i.w9);
    slot[3] = mac_slot(mac_i.y_mode, 1'b1, mac_i.y_sel, mac_i.w10,
      mac_i.w11);
    slot_v = {mac_i.valid, mac_i.valid, req_i.valid, req_i.valid};
  end

  // One generator per slot
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : gen_slot
      // Prefetch slots take the prefetch offset
      always_comb
        res_next[g] = calc(slot[g], slot_v[g],
          (g >= 2) ? mac_i.ofs_val : req_i.ofs_val, req_i.lit,
          cfg_reg[0], cfg_reg[1], cfg_reg[2], cfg_reg[3],
          cfg_reg[4]);
    end
  endgenerate

  // Operand one and prefetch legality
  always_comb
  begin
    op1_next = req_i.valid ? req_i.ofs_val : op1_reg;
    mac_bad_next = mac_i.valid &&
      ((mac_i.x_mode == oag_pkg::MAC_IDX && !mac_i.x_sel) ||
       (mac_i.y_mode == oag_pkg::MAC_IDX && !mac_i.y_sel) ||
       mac_i.x_mode > oag_pkg::MAC_IDX ||
       mac_i.y_mode > oag_pkg::MAC_IDX);
    last_ea_next = req_i.valid ? res_next[0].ea : last_ea_reg;
  end

  // Result registers
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      res_reg <= '0;
      op1_reg <= 16'h0000;
      mac_bad_reg <= 1'b0;
      last_ea_reg <= 16'h0000;
    end
    else
    begin
      res_reg <= res_next;
      op1_reg <= op1_next;
      mac_bad_reg <= mac_bad_next;
      last_ea_reg <= last_ea_next;
    end
  end

  assign res_o = res_reg;
  assign op1_o = op1_reg;
  assign mac_bad_o = mac_bad_reg;

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------

  // Next state, read capture and byte-lane writes
  always_comb
  begin
    bus_next = bus_reg;
    dat_next = dat_reg;
    for (int i = 0; i < `OAG_NUM_CFG; i++)
      cfg_next[i] = cfg_reg[i];
    rd_idx = reg_idx(wb_adr_i);
    case (bus_reg)
      // Take request, latch read data
      oag_pkg::BUS_IDLE:
        if (wb_cyc_i && wb_stb_i)
        begin
          bus_next = oag_pkg::BUS_ACK;
          if (rd_idx < 3'h5)
            dat_next = {16'h0000, cfg_reg[rd_idx]};
          else if (rd_idx == 3'h5)
            dat_next = {16'h0000, last_ea_reg};
          else
            dat_next = 32'h0000_0000;
        end
      // Write lands on the acknowledging edge
      oag_pkg::BUS_ACK:
      begin
        bus_next = oag_pkg::BUS_IDLE;
        if (wb_we_i && rd_idx < 3'h5)
        begin
          if (wb_sel_i[0])
            cfg_next[rd_idx][7:0] = wb_dat_i[7:0];
          if (wb_sel_i[1])
            cfg_next[rd_idx][15:8] = wb_dat_i[15:8];
        end
      end
      default:
        bus_next = oag_pkg::BUS_IDLE;
    endcase
  end

  // Bus and configuration registers
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bus_reg <= oag_pkg::BUS_IDLE;
      dat_reg <= 32'h0000_0000;
      cfg_reg[0] <= `OAG_CTRL_RST;
      for (int i = 1; i < `OAG_NUM_CFG; i++)
        cfg_reg[i] <= `OAG_BOUND_RST;
    end
    else
    begin
      bus_reg <= bus_next;
      dat_reg <= dat_next;
      for (int i = 0; i < `OAG_NUM_CFG; i++)
        cfg_reg[i] <= cfg_next[i];
    end
  end

  assign wb_ack_o = bus_reg == oag_pkg::BUS_ACK;
  assign wb_dat_o = dat_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  logic [15:0] chk_idx_sum; // Expected indexed address
  assign chk_idx_sum = req_i.src.wn_val + req_i.ofs_val;

  property p_file;
    req_i.valid && req_i.src.mode == oag_pkg::M_FILE |=>
      res_o[0].ea[15:13] == 3'b000 &&
      res_o[0].ea[12:0] == $past(req_i.lit[12:0]);
  endproperty
  a_file: assert property (p_file)
    else $error("file address not 13-bit direct");

  property p_op1;
    req_i.valid ##1 !req_i.valid |-> op1_o == $past(req_i.ofs_val);
  endproperty
  a_op1: assert property (p_op1)
    else $error("operand one not held from offset register");

  property p_post;
    req_i.valid && req_i.src.mode == oag_pkg::M_POST &&
      !req_i.src.space_y |=> res_o[0].ea == $past(req_i.src.wn_val) &&
      res_o[0].wr_en && res_o[0].wr_idx == $past(req_i.src.wn_idx);
  endproperty
  a_post: assert property (p_post)
    else $error("post-modify address is not the old pointer");

  property p_pre;
    req_i.valid && req_i.src.mode == oag_pkg::M_PRE |=>
      res_o[0].wr_en && res_o[0].ea == res_o[0].wr_val;
  endproperty
  a_pre: assert property (p_pre)
    else $error("pre-modify address differs from write-back");

  property p_idx;
    req_i.valid && req_i.src.mode == oag_pkg::M_IDX &&
      !req_i.src.space_y && !cfg_reg[0][`OAG_X_EN_BIT] |=>
      res_o[0].ea == $past(chk_idx_sum);
  endproperty
  a_idx: assert property (p_idx)
    else $error("indexed address is not pointer plus offset");

  property p_nowb;
    req_i.valid && (req_i.src.mode == oag_pkg::M_IDX ||
      req_i.src.mode == oag_pkg::M_LITOFF) |=> !res_o[0].wr_en;
  endproperty
  a_nowb: assert property (p_nowb)
    else $error("offset mode wrote the pointer back");

  property p_mac;
    mac_i.valid |=> res_o[2].wr_idx[3:1] == 3'b100 &&
      res_o[3].wr_idx[3:1] == 3'b101 && res_o[2].valid;
  endproperty
  a_mac: assert property (p_mac)
    else $error("prefetch pointer routed to wrong space");

  property p_yword;
    res_o[3].circ |-> res_o[3].ea[0] == 1'b0 &&
      (!res_o[3].wr_en || res_o[3].wr_val[0] == 1'b0);
  endproperty
  a_yword: assert property (p_yword)
    else $error("Y circular address has bit 0 set");

  property p_xoff;
    req_i.valid && !req_i.src.space_y &&
      (!cfg_reg[0][`OAG_X_EN_BIT] ||
       cfg_reg[0][`OAG_XSEL_MSB:`OAG_XSEL_LSB] == `OAG_SEL_OFF)
      |=> !res_o[0].circ;
  endproperty
  a_xoff: assert property (p_xoff)
    else $error("X circular active while disabled");

  property p_ack;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack)
    else $error("bus acknowledge longer than one cycle");

  c_post: cover property (req_i.valid &&
    req_i.src.mode == oag_pkg::M_POST ##1 res_o[0].wr_en);
  c_wrap: cover property (res_o[0].circ && res_o[0].wr_en);
  c_mac_idx: cover property (mac_i.valid &&
    mac_i.x_mode == oag_pkg::MAC_IDX && mac_i.x_sel);
  c_wr: cover property (wb_ack_o && wb_we_i);

endmodule

// file: design/oag_defines.svh
// Constants of the operand address generator: register offsets,
// control field positions and reset values.
// Assumes inclusion by bare name from the design files.
`ifndef OAG_DEFINES_SVH
`define OAG_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets on the Wishbone bus
// ----------------------------------------------------------------
`define OAG_ADR_CTRL 8'h00
`define OAG_ADR_XSTART 8'h04
`define OAG_ADR_XEND 8'h08
`define OAG_ADR_YSTART 8'h0C
`define OAG_ADR_YEND 8'h10
`define OAG_ADR_LAST_EA 8'h14

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define OAG_XSEL_LSB 0
`define OAG_XSEL_MSB 3
`define OAG_YSEL_LSB 4
`define OAG_YSEL_MSB 7
`define OAG_Y_EN_BIT 14
`define OAG_X_EN_BIT 15
`define OAG_SEL_OFF 4'hF

// ----------------------------------------------------------------
// Reset values and fixed widths
// ----------------------------------------------------------------
`define OAG_CTRL_RST 16'h00FF
`define OAG_BOUND_RST 16'h0000
`define OAG_NUM_CFG 5
`define OAG_FILE_BITS 13

`endif

// file: design/oag_pkg.sv
// Types of the operand address generator: modes, request and
// result carriers, bus state.
// Assumes oag_defines.svh holds all numeric constants.
package oag_pkg;

  // Addressing and operand forms for one slot
  typedef enum logic [3:0] {
    M_FILE = 4'h0, M_DIRECT = 4'h1, M_IND = 4'h2, M_POST = 4'h3,
    M_PRE = 4'h4, M_IDX = 4'h5, M_LITOFF = 4'h6, M_LIT5 = 4'h7,
    M_BRA = 4'h8, M_INTERRUPT_DISABLE_INSTR = 4'h9
  } oag_mode_t;

  // Multiply-accumulate prefetch forms
  typedef enum logic [2:0] {
    MAC_IND = 3'h0, MAC_POST2 = 3'h1, MAC_POST4 = 3'h2,
    MAC_POST6 = 3'h3, MAC_IDX = 3'h4
  } oag_mac_mode_t;

  // One address slot: mode, space, pointer and its step
  typedef struct packed {
    oag_mode_t mode;
    logic space_y;
    logic [3:0] wn_idx;
    logic [15:0] wn_val;
    logic [15:0] step;
  } oag_slot_t;

  // Decoder request: source and destination share one offset
  typedef struct packed {
    logic valid;
    oag_slot_t src;
    oag_slot_t dst;
    logic [15:0] ofs_val;
    logic [15:0] lit;
  } oag_req_t;

  // Dual prefetch request
  typedef struct packed {
    logic valid;
    logic x_sel;
    oag_mac_mode_t x_mode;
    logic y_sel;
    oag_mac_mode_t y_mode;
    logic [15:0] w8;
    logic [15:0] w9;
    logic [15:0] w10;
    logic [15:0] w11;
    logic [15:0] ofs_val;
  } oag_mac_t;

  // Result of one slot
  typedef struct packed {
    logic valid;
    logic [15:0] ea;
    logic [15:0] opnd;
    logic wr_en;
    logic [3:0] wr_idx;
    logic [15:0] wr_val;
    logic circ;
  } oag_res_t;

  // Bus slave states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01, BUS_ACK = 2'b10
  } oag_bus_state_t;

endpackage
